/* File: core/adcsq_defines.vh */
/*
 * register offsets, field positions and reset values of the sample
 * sequencer control block. assumes a 32-bit register bus, byte addresses.
 */
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADCSQ_RAW_IRQ      8'h04
`define ADCSQ_IRQ_MASK     8'h08
`define ADCSQ_OVERFLOW     8'h10
`define ADCSQ_UNDERFLOW    8'h18
`define ADCSQ_START        8'h28
`define ADCSQ_SEL0         8'h40
`define ADCSQ_CTL0         8'h44
`define ADCSQ_RES0         8'h48
`define ADCSQ_STAT0        8'h4c
`define ADCSQ_SEL1         8'h60
`define ADCSQ_CTL1         8'h64
`define ADCSQ_RES1         8'h68
`define ADCSQ_STAT1        8'h6c
`define ADCSQ_SEL2         8'h80
`define ADCSQ_CTL2         8'h84
`define ADCSQ_RES2         8'h88
`define ADCSQ_STAT2        8'h8c
`define ADCSQ_SEL3         8'ha0
`define ADCSQ_CTL3         8'ha4
`define ADCSQ_RES3         8'ha8
`define ADCSQ_STAT3        8'hac

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define ADCSQ_F_DIFF       0
`define ADCSQ_F_LAST       1
`define ADCSQ_F_IRQ        2
`define ADCSQ_F_SENSOR     3
`define ADCSQ_STAT_EMPTY   8
`define ADCSQ_STAT_FULL    12
`define ADCSQ_RES_W        10
`define ADCSQ_FIFO_DEPTH   4'h8
`define ADCSQ_CTL_RESET    32'h00000000
`define ADCSQ_SEQ3_MASK    32'h0000000f
`define ADCSQ_SEQ12_MASK   32'h0000ffff
`define ADCSQ_MUX_MASK     32'h77777777
`define ADCSQ_RESP_OKAY    2'b00
`define ADCSQ_RESP_SLVERR  2'b10

`endif

/* File: core/adcsq_top.v */
/*
 * sample sequencer control and result path: four sequencers with per-slot
 * control and input-select words, one result FIFO each, read-to-pop result
 * registers, status, overflow/underflow and interrupt registers on an
 * AXI4-Lite slave.
 * assumes an outside converter that takes conv_req with the slot setup and
 * answers once with conv_done and conv_data; one clock, synchronous reset.
 */
`include "adcsq_defines.vh"

// Contract
// - any number of slots may request an interrupt in one sequence
// - each slot has a last flag; a set flag ends the sequence there
// - slots after the first flagged last slot are never converted
// - fourth sequencer has one slot with its last flag fixed at one
// - differential slot converts pair i, inputs 2i and 2i+1
// - temperature sensor has no differential mode
// - slot n control nibble: sensor, irq enable, last, diff; reset zero
// - result reads return slot order, data in bits 9:0, rest zero
// - reading a result register pops that FIFO entry
// - one result FIFO and result register per sequencer
// - push into full FIFO flags overflow, read of empty flags underflow
// - each FIFO has its own read-only status register
// - sensor bit picks the temperature sensor, else the selected pin
// - irq enable raises raw interrupt at slot end; mask gates output
// - input select is three bits in nibble n, top nibble bit reserved
module adcsq_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         conv_req,
    output reg         conv_sensor,
    output reg         conv_diff,
    output reg  [2:0]  conv_input,
    input  wire        conv_done,
    input  wire [9:0]  conv_data,
    output reg         irq
);

    // ----------------------------------------------------------------
    // state and storage
    // ----------------------------------------------------------------
    localparam S_IDLE = 1'b0;
    localparam S_CONV = 1'b1;

    reg  [31:0] ctl [0:3];
    reg  [31:0] mux [0:3];
    reg  [9:0]  fifo_mem [0:31];
    reg  [2:0]  head [0:3];
    reg  [2:0]  tail [0:3];
    reg  [3:0]  count [0:3];
    reg  [3:0]  raw_irq;
    reg  [3:0]  irq_mask;
    reg  [3:0]  overflow;
    reg  [3:0]  underflow;
    reg  [3:0]  pending;
    reg         state;
    reg  [1:0]  cur_seq;
    reg  [2:0]  cur_slot;
    reg  [7:0]  wr_addr;
    reg  [31:0] wr_data;
    reg  [3:0]  wr_strb;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // highest slot index a sequencer owns
    function [2:0] final_slot;
        input [1:0] seq;
        begin
            case (seq)
                2'd0:    final_slot = 3'd7;
                2'd3:    final_slot = 3'd0;
                default: final_slot = 3'd3;
            endcase
        end
    endfunction

    function [31:0] ctl_mask;
        input [1:0] seq;
        begin
            case (seq)
                2'd0:    ctl_mask = 32'hffffffff;
                2'd3:    ctl_mask = `ADCSQ_SEQ3_MASK;
                default: ctl_mask = `ADCSQ_SEQ12_MASK;
            endcase
        end
    endfunction

    // control nibble of one slot
    function [3:0] slot_ctl;
        input [1:0] seq;
        input [2:0] slot;
        reg   [31:0] word;
        begin
            word = ctl[seq];
            slot_ctl = word[{slot, 2'b00} +: 4];
            if (seq == 2'd3)
                slot_ctl[`ADCSQ_F_LAST] = 1'b1;
        end
    endfunction

    function [2:0] slot_mux;
        input [1:0] seq;
        input [2:0] slot;
        reg   [31:0] word;
        begin
            word = mux[seq];
            slot_mux = word[{slot, 2'b00} +: 3];
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = data[i*8 +: 8];
        end
    endfunction

    function [31:0] fifo_status;
        input [2:0] hp;
        input [2:0] tp;
        input [3:0] cnt;
        begin
            fifo_status = {19'h00000, (cnt == `ADCSQ_FIFO_DEPTH), 3'h0,
                           (cnt == 4'h0), 1'b0, hp, 1'b0, tp};
        end
    endfunction

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire        rd_take = s_axi_arvalid & s_axi_arready;
    wire        wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire [1:0]  rd_seq  = s_axi_araddr[6:5] - 2'd2;
    wire        rd_res  = rd_take && s_axi_araddr[4:0] == 5'h08 &&
                          s_axi_araddr[7:5] >= 3'd2 && s_axi_araddr[7:5] <= 3'd5;
    wire        rd_empty = (count[rd_seq] == 4'h0);
    wire [1:0]  wr_seq  = wr_addr[6:5] - 2'd2;
    wire        wr_seqreg = wr_addr[7:5] >= 3'd2 && wr_addr[7:5] <= 3'd5;

    // push from the converter side
    wire        push     = (state == S_CONV) & conv_done;
    wire [3:0]  slot_now = slot_ctl(cur_seq, cur_slot);
    wire        push_ok  = push & (count[cur_seq] != `ADCSQ_FIFO_DEPTH);
    wire        pop      = rd_res & ~rd_empty;
    wire        seq_done = slot_now[`ADCSQ_F_LAST] |
                           (cur_slot == final_slot(cur_seq));

    reg  [31:0] rd_val;
    reg         rd_hit;
    always @* begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `ADCSQ_RAW_IRQ:   rd_val = {28'h0000000, raw_irq};
            `ADCSQ_IRQ_MASK:  rd_val = {28'h0000000, irq_mask};
            `ADCSQ_OVERFLOW:  rd_val = {28'h0000000, overflow};
            `ADCSQ_UNDERFLOW: rd_val = {28'h0000000, underflow};
            `ADCSQ_START:     rd_val = {28'h0000000, pending};
            `ADCSQ_SEL0, `ADCSQ_SEL1, `ADCSQ_SEL2, `ADCSQ_SEL3:
                rd_val = mux[rd_seq];
            `ADCSQ_CTL0, `ADCSQ_CTL1, `ADCSQ_CTL2, `ADCSQ_CTL3: begin
                rd_val = ctl[rd_seq];
                if (rd_seq == 2'd3)
                    rd_val[`ADCSQ_F_LAST] = 1'b1;
            end
            `ADCSQ_RES0, `ADCSQ_RES1, `ADCSQ_RES2, `ADCSQ_RES3:
                rd_val = {22'h000000, fifo_mem[{rd_seq, tail[rd_seq]}]};
            `ADCSQ_STAT0, `ADCSQ_STAT1, `ADCSQ_STAT2, `ADCSQ_STAT3:
                rd_val = fifo_status(head[rd_seq], tail[rd_seq], count[rd_seq]);
            default:
                rd_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    // one write and one read in flight; write fires once both halves landed
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ADCSQ_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ADCSQ_RESP_OKAY;
            wr_addr       <= 8'h00;
            wr_data       <= 32'h00000000;
            wr_strb       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_seqreg && wr_addr[4:2] <= 3'd1) ||
                                wr_addr == `ADCSQ_IRQ_MASK ||
                                wr_addr == `ADCSQ_START ?
                                `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (rd_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= (rd_res && rd_empty) ? 32'h00000000 : rd_val;
                s_axi_rresp   <= rd_hit ? `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    integer k, j, p;
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (j = 0; j < 4; j = j + 1) begin
                ctl[j] <= `ADCSQ_CTL_RESET;
                mux[j] <= 32'h00000000;
            end
            irq_mask <= 4'h0;
        end else if (wr_go) begin
            if (wr_seqreg && wr_addr[4:0] == 5'h04)
                ctl[wr_seq] <= merge(ctl[wr_seq], wr_data, wr_strb) &
                               ctl_mask(wr_seq);
            if (wr_seqreg && wr_addr[4:0] == 5'h00)
                mux[wr_seq] <= merge(mux[wr_seq], wr_data, wr_strb) &
                               ctl_mask(wr_seq) & `ADCSQ_MUX_MASK;
            if (wr_addr == `ADCSQ_IRQ_MASK && wr_strb[0])
                irq_mask <= wr_data[3:0];
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    reg [1:0] pick;
    always @* begin
        pick = 2'd3;
        for (p = 3; p >= 0; p = p - 1)
            if (pending[p])
                pick = p[1:0];
    end

    wire [2:0] next_slot = cur_slot + 3'd1;
    wire [1:0] load_seq  = (state == S_IDLE) ? pick : cur_seq;
    wire [2:0] load_slot = (state == S_IDLE) ? 3'd0 : next_slot;
    wire [3:0] load_ctl  = slot_ctl(load_seq, load_slot);
    wire       start_req = (state == S_IDLE) && (pending != 4'h0);
    wire       next_req  = push && !seq_done;
    wire [3:0] start_set = (wr_go && wr_addr == `ADCSQ_START && wr_strb[0]) ?
                           wr_data[3:0] : 4'h0;

    always @(posedge aclk) begin
        if (!aresetn) begin
            state       <= S_IDLE;
            cur_seq     <= 2'd0;
            cur_slot    <= 3'd0;
            pending     <= 4'h0;
            conv_req    <= 1'b0;
            conv_sensor <= 1'b0;
            conv_diff   <= 1'b0;
            conv_input  <= 3'd0;
        end else begin
            pending <= (pending & ~(start_req ? (4'h1 << pick) : 4'h0)) | start_set;
            case (state)
                S_IDLE: begin
                    if (start_req) begin
                        state    <= S_CONV;
                        cur_seq  <= pick;
                        cur_slot <= 3'd0;
                    end
                end
                S_CONV: begin
                    if (push) begin
                        if (seq_done)
                            state <= S_IDLE;
                        else
                            cur_slot <= next_slot;
                    end
                end
                default: state <= S_IDLE;
            endcase
            if (start_req || next_req) begin
                conv_req    <= 1'b1;
                conv_sensor <= load_ctl[`ADCSQ_F_SENSOR];
                conv_diff   <= load_ctl[`ADCSQ_F_DIFF] &
                               ~load_ctl[`ADCSQ_F_SENSOR];
                conv_input  <= slot_mux(load_seq, load_slot);
            end else if (push) begin
                conv_req <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // result FIFOs
    // ----------------------------------------------------------------
    // one FIFO per sequencer; a full FIFO drops the new result
    always @(posedge aclk) begin
        if (push_ok)
            fifo_mem[{cur_seq, head[cur_seq]}] <= conv_data;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            for (k = 0; k < 4; k = k + 1) begin
                head[k]  <= 3'd0;
                tail[k]  <= 3'd0;
                count[k] <= 4'h0;
            end
        end else begin
            for (k = 0; k < 4; k = k + 1) begin
                if (push_ok && cur_seq == k[1:0])
                    head[k] <= head[k] + 3'd1;
                if (pop && rd_seq == k[1:0])
                    tail[k] <= tail[k] + 3'd1;
                if ((push_ok && cur_seq == k[1:0]) && !(pop && rd_seq == k[1:0]))
                    count[k] <= count[k] + 4'h1;
                else if (!(push_ok && cur_seq == k[1:0]) && (pop && rd_seq == k[1:0]))
                    count[k] <= count[k] - 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // status and interrupt
    // ----------------------------------------------------------------
    // all sticky flags clear on a read of their register; a set in the same
    // cycle wins so no event is lost
    wire [3:0] seq_bit  = 4'h1 << cur_seq;
    wire [3:0] set_raw  = (push && slot_now[`ADCSQ_F_IRQ]) ? seq_bit : 4'h0;
    wire [3:0] set_ovf  = (push && !push_ok) ? seq_bit : 4'h0;
    wire [3:0] set_udf  = (rd_res && rd_empty) ? (4'h1 << rd_seq) : 4'h0;

    always @(posedge aclk) begin
        if (!aresetn) begin
            raw_irq   <= 4'h0;
            overflow  <= 4'h0;
            underflow <= 4'h0;
            irq       <= 1'b0;
        end else begin
            raw_irq   <= ((rd_take && s_axi_araddr == `ADCSQ_RAW_IRQ) ?
                         4'h0 : raw_irq) | set_raw;
            overflow  <= ((rd_take && s_axi_araddr == `ADCSQ_OVERFLOW) ?
                         4'h0 : overflow) | set_ovf;
            underflow <= ((rd_take && s_axi_araddr == `ADCSQ_UNDERFLOW) ?
                         4'h0 : underflow) | set_udf;
            irq       <= |(raw_irq & irq_mask);
        end
    end

endmodule // adcsq_top

/* File: tb/adcsq_asserts.sv */
/*
 * checks on adcsq_top: bus answer timing, request hold, result layout.
 * assumes it sees only the top ports; attached by the bind below.
 */
module adcsq_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        conv_req,
    input wire        conv_sensor,
    input wire        conv_diff,
    input wire [2:0]  conv_input,
    input wire        conv_done
);
    timeunit 1ns;
    timeprecision 1ps;
    reg rd_res;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // result regs at 0x48/0x68/0x88/0xa8
    always @(posedge aclk) begin
        if (!aresetn)
            rd_res <= 1'b0;
        else if (s_axi_arvalid && s_axi_arready)
            rd_res <= s_axi_araddr[4:0] == 5'h08 && s_axi_araddr[7:5] >= 3'd2
                      && s_axi_araddr[7:5] <= 3'd5;
    end

    req_hold_a: assert property (conv_req && !conv_done |=> conv_req)
        else $error("request dropped");
    setup_hold_a: assert property (conv_req && !conv_done |=>
        $stable({conv_sensor, conv_diff, conv_input}))
        else $error("setup changed");
    sensor_diff_a: assert property (conv_req && conv_sensor |-> !conv_diff)
        else $error("diff with sensor");
    req_end_a: assert property ($past(aresetn) && $fell(conv_req) |-> $past(conv_done))
        else $error("request ended early");
    res_word_a: assert property (s_axi_rvalid && rd_res |-> s_axi_rdata[31:10] == 22'h0)
        else $error("result high bits set");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata not held");
    write_ans_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("bresp late");
    read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late");
endmodule // adcsq_chk

bind adcsq_top adcsq_chk i_chk (.*);

/* File: tb/adcsq_conv_model.sv */
/*
 * converter model: one done pulse per request after gap cycles, the
 * result encoding the setup and a count. assumes the top's clock and reset.
 */
module adcsq_conv_model (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [2:0] gap,
    input  wire       conv_req,
    input  wire       conv_sensor,
    input  wire       conv_diff,
    input  wire [2:0] conv_input,
    output reg        conv_done,
    output reg  [9:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [2:0] wait_cnt;
    reg [4:0] conv_cnt;

    // data toggles outside done so stale data cannot pass
    always @(posedge aclk) begin
        if (!aresetn) begin
            conv_done <= 1'b0;
            wait_cnt <= 3'h0;
            conv_cnt <= 5'h00;
            conv_data <= 10'h155;
        end else if (conv_done) begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            wait_cnt <= gap;
        end else if (conv_req && wait_cnt == 3'h0) begin
            conv_done <= 1'b1;
            conv_cnt <= conv_cnt + 5'h01;
            conv_data <= conv_sensor ? {2'b10, 3'h0, conv_cnt}
                                     : {1'b0, conv_diff, conv_input, conv_cnt};
        end else begin
            wait_cnt <= conv_req ? wait_cnt - 3'h1 : wait_cnt;
            conv_data <= ~conv_data;
        end
    end
endmodule // adcsq_conv_model

/* File: tb/tb.sv */
/*
 * self-checking bench for adcsq_top: random setups, drain, status, irq.
 * assumes adcsq_conv_model and the bound checker.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata, seed, d, c, m, mk, msk;
    reg  [3:0]  s_axi_wstrb;
    reg  [2:0]  gap;
    reg  [1:0]  r;
    reg  [31:0] ctl [0:3];
    reg  [31:0] mux [0:3];
    reg  [2:0]  ptr [0:3];
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        conv_req, conv_sensor, conv_diff, conv_done, irq;
    wire [2:0]  conv_input;
    wire [9:0]  conv_data;
    integer     bad_count, cmp_count, total, base, n, s;

    adcsq_top        i_dut (.*);
    adcsq_conv_model i_conv (.*);

    always @(posedge aclk) begin
        if (!aresetn) total <= 0;
        else if (conv_done) total <= total + 1;
    end
    // --------
    // expectations
    // --------
    function [31:0] rnd;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed;
        end
    endfunction
    function integer lim(input integer q);
        lim = (q == 0) ? 8 : (q == 3) ? 1 : 4;
    endfunction
    function integer nslots(input integer q);
        integer k;
        begin
            nslots = lim(q);
            for (k = lim(q) - 1; k >= 0; k = k - 1) if (ctl[q][4*k+1]) nslots = k + 1;
        end
    endfunction
    function [31:0] irqexp(input integer q);
        integer k;
        begin
            irqexp = 0;
            for (k = 0; k < nslots(q); k = k + 1) if (ctl[q][4*k+2]) irqexp = 32'h1 << q;
        end
    endfunction
    function [31:0] expv(input integer q, input integer i, input integer cn);
        reg [31:0] f, mm;
        begin
            f = ctl[q] >> (4 * i);
            mm = mux[q] >> (4 * i);
            expv = f[3] ? {22'h0, 2'b10, 3'h0, cn[4:0]} : {22'h0, 1'b0, f[0], mm[2:0], cn[4:0]};
        end
    endfunction
    function [7:0] seq_base(input integer q);
        seq_base = 8'h40 + 8'h20 * q[1:0];
    endfunction
    function [31:0] stat(input integer q, input reg full);
        stat = {19'h0, full, 3'h0, ~full, 1'b0, ptr[q], 1'b0, ptr[q]};
    endfunction
    // --------
    // tasks
    // --------
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("counts: %0d compares, %0d wrong", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task tout;
        begin
            bad_count = bad_count + 1;
            finish_test;
        end
    endtask
    task wr(input [7:0] a, input [31:0] dv, output [1:0] rv);
        integer t;
        reg got;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= dv;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            got = 0;
            t = 0;
            while (!got && t < 200) begin
                @(posedge aclk);
                t = t + 1;
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
                rv = s_axi_bresp;
                got = s_axi_bvalid;
            end
            if (!got) tout;
        end
    endtask
    // rready lags two cycles so rvalid must stand
    task rd(input [7:0] a, output [31:0] dv, output [1:0] rv);
        integer t;
        reg got;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            got = 0;
            t = 0;
            while (!got && t < 200) begin
                @(posedge aclk);
                t = t + 1;
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rready && s_axi_rvalid) begin
                    dv = s_axi_rdata;
                    rv = s_axi_rresp;
                    got = 1;
                    s_axi_rready <= 1'b0;
                end else s_axi_rready <= (t >= 2);
            end
            if (!got) tout;
        end
    endtask
    task run(input integer q);
        integer t, b;
        begin
            b = total;
            t = 0;
            wr(8'h28, 32'h1 << q, r);
            while ((total < b + nslots(q) || conv_req) && t < 400) begin
                @(posedge aclk);
                t = t + 1;
            end
            if (t >= 400) tout;
            // room for a stray conversion
            repeat (12) @(posedge aclk);
            chk(total - b, nslots(q));
        end
    endtask
    task drain(input integer q, input integer c0, input integer cnt);
        integer i;
        begin
            for (i = 0; i < cnt; i = i + 1) begin
                rd(seq_base(q) + 8'h08, d, r);
                chk(d, expv(q, i % nslots(q), c0 + i));
            end
            ptr[q] = ptr[q] + cnt[2:0];
        end
    endtask
    // --------
    // main sequence
    // --------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        s_axi_wstrb = 4'hf;
        gap = 3'h0;
        seed = 32'h1d2e;
        bad_count = 0;
        cmp_count = 0;
        for (s = 0; s < 4; s = s + 1) ptr[s] = 3'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (s = 0; s < 4; s = s + 1) begin
            rd(seq_base(s) + 8'h04, d, r);
            chk(d, (s == 3) ? 32'h2 : 32'h0);
            rd(seq_base(s) + 8'h0c, d, r);
            chk(d, 32'h100);
        end
        rd(8'hfc, d, r);
        chk(r, 2'b10);
        wr(8'h48, 32'h1, r);
        chk(r, 2'b10);
        $display("test access done");
        for (n = 0; n < 8; n = n + 1) begin
            s = n % 4;
            c = rnd();
            gap <= c[2:0];
            c = rnd() | ((s == 3) ? 32'h0 : 32'h2 << (4 * (rnd() % lim(s))));
            m = rnd();
            msk = rnd() & 32'hf;
            mk = (s == 0) ? 32'hffffffff : (s == 3) ? 32'hf : 32'hffff;
            wr(seq_base(s) + 8'h04, c, r);
            wr(seq_base(s), m, r);
            wr(8'h08, msk, r);
            ctl[s] = (s == 3) ? ((c & 32'hd) | 32'h2) : (c & mk);
            mux[s] = m & mk & 32'h77777777;
            rd(seq_base(s) + 8'h04, d, r);
            chk(d, ctl[s]);
            rd(seq_base(s), d, r);
            chk(d, mux[s]);
            base = total;
            run(s);
            chk({31'h0, irq}, (irqexp(s) & msk) != 0);
            rd(8'h04, d, r);
            chk(d, irqexp(s));
            drain(s, base, nslots(s));
            chk({31'h0, irq}, 32'h0);
            rd(seq_base(s) + 8'h0c, d, r);
            chk(d, stat(s, 1'b0));
            rd(seq_base(s) + 8'h08, d, r);
            chk(d, 32'h0);
            rd(seq_base(s) + 8'h0c, d, r);
            chk(d, stat(s, 1'b0));
            rd(8'h18, d, r);
            chk(d, 32'h1 << s);
            $display("test round %0d seq %0d done", n, s);
        end
        // the third run of four slots overflows the depth-8 fifo
        ctl[1] = 32'h2000;
        mux[1] = 32'h1234;
        wr(8'h64, ctl[1], r);
        wr(8'h60, mux[1], r);
        base = total;
        for (n = 0; n < 3; n = n + 1) run(1);
        rd(8'h6c, d, r);
        chk(d, stat(1, 1'b1));
        rd(8'h10, d, r);
        chk(d, 32'h2);
        drain(1, base, 8);
        rd(8'h6c, d, r);
        chk(d, stat(1, 1'b0));
        $display("test overflow done");
        finish_test;
    end
endmodule // tb
